// *** hdl/bsel_pkg.sv ***
// bsel_pkg: boot source codes, medium enumeration and pin mux constants
// assumes: shared by the boot source selector and its decode table module
package bsel_pkg;

  // media the boot rom can be told to use
  typedef enum logic [3:0] {
    BSEL_MED_NONE   = 4'h0,
    BSEL_MED_SER0   = 4'h1,
    BSEL_MED_QFLASH = 4'h2,
    BSEL_MED_SMEM8  = 4'h3,
    BSEL_MED_SMEM16 = 4'h4,
    BSEL_MED_SMEM32 = 4'h5,
    BSEL_MED_USB1ST = 4'h6,
    BSEL_MED_USB2ND = 4'h7,
    BSEL_MED_SSPI   = 4'h8,
    BSEL_MED_SER3   = 4'h9
  } bsel_medium_t;

  // fuse field codes
  localparam logic [3:0] FLD_PINSTATE = 4'h0;
  localparam logic [3:0] FLD_SER0     = 4'h1;
  localparam logic [3:0] FLD_QFLASH   = 4'h2;
  localparam logic [3:0] FLD_SMEM8    = 4'h3;
  localparam logic [3:0] FLD_SMEM16   = 4'h4;
  localparam logic [3:0] FLD_SMEM32   = 4'h5;
  localparam logic [3:0] FLD_USB1ST   = 4'h6;
  localparam logic [3:0] FLD_USB2ND   = 4'h7;
  localparam logic [3:0] FLD_SSPI     = 4'h8;
  localparam logic [3:0] FLD_SER3     = 4'h9;

  // strap codes, strap 3 is the msb
  localparam logic [3:0] STR_SER0     = 4'h0;
  localparam logic [3:0] STR_QFLASH   = 4'h1;
  localparam logic [3:0] STR_SMEM8    = 4'h2;
  localparam logic [3:0] STR_SMEM16   = 4'h3;
  localparam logic [3:0] STR_SMEM32   = 4'h4;
  localparam logic [3:0] STR_USB1ST   = 4'h5;
  localparam logic [3:0] STR_USB2ND   = 4'h6;
  localparam logic [3:0] STR_SSPI     = 4'h7;
  localparam logic [3:0] STR_SER3     = 4'h8;

  // pin function codes for the four shared flash port pins
  localparam logic [2:0] PFN_GPIO     = 3'h0;
  localparam logic [2:0] PFN_SSP      = 3'h2;
  localparam logic [2:0] PFN_QFLASH   = 3'h3;

  // boot rom: 64 kB, 16 address bits
  localparam int          BOOT_ROM_KB   = 64;
  localparam logic [31:0] BOOT_ROM_BASE = 32'h1040_0000;

  // static memory data width codes on chip select zero
  localparam logic [1:0] SMW_8  = 2'h0;
  localparam logic [1:0] SMW_16 = 2'h1;
  localparam logic [1:0] SMW_32 = 2'h2;

endpackage

// *** hdl/bsel_decode.sv ***
// bsel_decode: combinational code to medium table for fuse or strap codes
// assumes: code and source chosen upstream; result registered by caller
`timescale 1ns/1ns
module bsel_decode (
  input  wire logic                  from_strap_i,
  input  wire logic [3:0]            code_i,
  output bsel_pkg::bsel_medium_t     medium_o,
  output logic                       invalid_o
);

  // table lookup; reserved codes give no medium
  always_comb begin
    medium_o  = bsel_pkg::BSEL_MED_NONE;
    invalid_o = 1'b0;
    if (from_strap_i) begin
      unique case (code_i)                                   // [RQ9]
        bsel_pkg::STR_SER0:   medium_o = bsel_pkg::BSEL_MED_SER0;    // [RQ10]
        bsel_pkg::STR_QFLASH: medium_o = bsel_pkg::BSEL_MED_QFLASH;  // [RQ10]
        bsel_pkg::STR_SMEM8:  medium_o = bsel_pkg::BSEL_MED_SMEM8;   // [RQ11]
        bsel_pkg::STR_SMEM16: medium_o = bsel_pkg::BSEL_MED_SMEM16;  // [RQ11]
        bsel_pkg::STR_SMEM32: medium_o = bsel_pkg::BSEL_MED_SMEM32;  // [RQ11]
        bsel_pkg::STR_USB1ST: medium_o = bsel_pkg::BSEL_MED_USB1ST;  // [RQ12]
        bsel_pkg::STR_USB2ND: medium_o = bsel_pkg::BSEL_MED_USB2ND;  // [RQ12]
        bsel_pkg::STR_SSPI:   medium_o = bsel_pkg::BSEL_MED_SSPI;    // [RQ12]
        bsel_pkg::STR_SER3:   medium_o = bsel_pkg::BSEL_MED_SER3;    // [RQ12]
        default:              invalid_o = 1'b1;                     // [RQ14]
      endcase
    end else begin
      unique case (code_i)
        bsel_pkg::FLD_SER0:   medium_o = bsel_pkg::BSEL_MED_SER0;    // [RQ2]
        bsel_pkg::FLD_QFLASH: medium_o = bsel_pkg::BSEL_MED_QFLASH;  // [RQ3]
        bsel_pkg::FLD_SMEM8:  medium_o = bsel_pkg::BSEL_MED_SMEM8;   // [RQ4]
        bsel_pkg::FLD_SMEM16: medium_o = bsel_pkg::BSEL_MED_SMEM16;  // [RQ4]
        bsel_pkg::FLD_SMEM32: medium_o = bsel_pkg::BSEL_MED_SMEM32;  // [RQ4]
        bsel_pkg::FLD_USB1ST: medium_o = bsel_pkg::BSEL_MED_USB1ST;  // [RQ5]
        bsel_pkg::FLD_USB2ND: medium_o = bsel_pkg::BSEL_MED_USB2ND;  // [RQ5]
        bsel_pkg::FLD_SSPI:   medium_o = bsel_pkg::BSEL_MED_SSPI;    // [RQ6]
        bsel_pkg::FLD_SER3:   medium_o = bsel_pkg::BSEL_MED_SER3;    // [RQ6]
        default:              invalid_o = 1'b1;                     // [RQ14]
      endcase
    end
  end

endmodule

// *** hdl/bsel_boot_source_selector.sv ***
// bsel_boot_source_selector: picks the boot medium after reset from fuses or straps
// assumes: fuse and strap inputs are synchronous to mclk_i and stable around reset
//
// Notes on behaviour
// RQ1: blank or zero fuse field uses straps
// RQ2: field 0001 boots serial port zero
// RQ3: field 0010 boots quad flash interface
// RQ4: fields 0011-0101 boot static memory 8/16/32
// RQ5: fields 0110, 0111 boot first, second usb
// RQ6: field 1000 sync serial flash, 1001 port three
// RQ7: sync serial boot maps four fixed pins
// RQ8: flash boots set distinct pin functions at reset
// RQ9: straps captured at reset, strap 3 msb
// RQ10: straps 0000 serial zero, 0001 quad flash
// RQ11: straps 0010-0100 static memory 8/16/32
// RQ12: straps 0101-0111 two usb, spi; 1000 serial three
// RQ13: after reset fetch starts in 64 kB rom
// RQ14: unlisted codes flagged invalid, no medium
`timescale 1ns/1ns
module bsel_boot_source_selector (
  input  wire logic                  mclk_i,
  input  wire logic                  sys_rst_i,
  input  wire logic                  fuse_programmed_i,
  input  wire logic [3:0]            boot_source_field_i,
  input  wire logic                  strap_pin_3_i,
  input  wire logic                  strap_pin_2_i,
  input  wire logic                  strap_pin_1_i,
  input  wire logic                  strap_pin_0_i,
  output logic                       boot_valid_o,
  output logic                       boot_invalid_o,
  output logic                       boot_from_strap_o,
  output bsel_pkg::bsel_medium_t     boot_medium_o,
  output logic [3:0]                 boot_code_o,
  output logic                       serial_port_zero_en_o,
  output logic                       serial_port_three_en_o,
  output logic                       quad_flash_interface_en_o,
  output logic                       external_memory_controller_en_o,
  output logic                       static_chip_select_zero_en_o,
  output logic [1:0]                 static_width_o,
  output logic                       usb_port_first_en_o,
  output logic                       usb_port_second_en_o,
  output logic                       sync_serial_port_zero_en_o,
  output logic [2:0]                 sync_serial_clock_fn_o,
  output logic [2:0]                 sync_serial_slave_select_fn_o,
  output logic [2:0]                 sync_serial_master_in_fn_o,
  output logic [2:0]                 sync_serial_master_out_fn_o,
  output logic                       fetch_from_rom_o,
  output logic [31:0]                fetch_addr_o
);

  ////////////////////////////////////////////////////////////////////////////
  // capture sequencer

  typedef enum logic [1:0] {
    BSEL_ST_RESET   = 2'b00,
    BSEL_ST_CAPTURE = 2'b01,
    BSEL_ST_DONE    = 2'b10
  } bsel_state_t;

  bsel_state_t state;
  bsel_state_t next_state;
  logic [3:0]  code;
  logic [3:0]  next_code;
  logic        strap_sel;
  logic        next_strap_sel;
  logic        use_strap;
  logic [3:0]  strap_code;
  bsel_pkg::bsel_medium_t dec_medium;
  logic        dec_invalid;

  // strap 3 is the most significant bit of the code
  assign strap_code = {strap_pin_3_i, strap_pin_2_i, strap_pin_1_i, strap_pin_0_i}; // [RQ9]
  // blank fuses or an all-zero field hand over to the straps
  assign use_strap = !fuse_programmed_i ||
                     (boot_source_field_i == bsel_pkg::FLD_PINSTATE);       // [RQ1]

  // levels are caught on the second clock after reset release, never under reset itself
  always_comb begin
    next_state     = state;
    next_code      = code;
    next_strap_sel = strap_sel;
    unique case (state)
      BSEL_ST_RESET: begin
        next_state = BSEL_ST_CAPTURE;
      end
      BSEL_ST_CAPTURE: begin
        next_strap_sel = use_strap;                                         // [RQ1]
        next_code      = use_strap ? strap_code : boot_source_field_i;      // [RQ9]
        next_state     = BSEL_ST_DONE;
      end
      BSEL_ST_DONE: begin
        next_state = BSEL_ST_DONE;
      end
      default: begin
        next_state = BSEL_ST_RESET;
      end
    endcase
  end

  // register only; choice holds until the next reset
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      state     <= BSEL_ST_RESET;
      code      <= 4'h0;
      strap_sel <= 1'b0;
    end else begin
      state     <= next_state;
      code      <= next_code;
      strap_sel <= next_strap_sel;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // decode

  bsel_decode u_decode (
    .from_strap_i (strap_sel),
    .code_i       (code),
    .medium_o     (dec_medium),
    .invalid_o    (dec_invalid)
  );

  ////////////////////////////////////////////////////////////////////////////
  // registered boot outputs

  logic                   done;
  bsel_pkg::bsel_medium_t next_medium;
  logic                   next_valid;
  logic                   next_invalid;
  logic [2:0]             next_fn;
  logic [1:0]             next_width;
  logic [2:0]             pin_fn;

  assign done = (state == BSEL_ST_DONE);

  // a reserved code never enables a medium
  always_comb begin
    next_valid   = done && !dec_invalid;                                    // [RQ14]
    next_invalid = done && dec_invalid;                                     // [RQ14]
    next_medium  = next_valid ? dec_medium : bsel_pkg::BSEL_MED_NONE;
    next_width   = bsel_pkg::SMW_8;
    unique case (next_medium)
      bsel_pkg::BSEL_MED_SMEM16: next_width = bsel_pkg::SMW_16;            // [RQ4]
      bsel_pkg::BSEL_MED_SMEM32: next_width = bsel_pkg::SMW_32;            // [RQ4]
      default:                   next_width = bsel_pkg::SMW_8;
    endcase
    // quad flash and sync serial claim the same pins with different functions
    if (next_medium == bsel_pkg::BSEL_MED_SSPI)
      next_fn = bsel_pkg::PFN_SSP;                                          // [RQ8]
    else if (next_medium == bsel_pkg::BSEL_MED_QFLASH)
      next_fn = bsel_pkg::PFN_QFLASH;                                       // [RQ8]
    else
      next_fn = bsel_pkg::PFN_GPIO;
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      boot_valid_o      <= 1'b0;
      boot_invalid_o    <= 1'b0;
      boot_from_strap_o <= 1'b0;
      boot_medium_o     <= bsel_pkg::BSEL_MED_NONE;
      boot_code_o       <= 4'h0;
      static_width_o    <= bsel_pkg::SMW_8;
      pin_fn            <= bsel_pkg::PFN_GPIO;
      fetch_from_rom_o  <= 1'b1;
    end else begin
      boot_valid_o      <= next_valid;
      boot_invalid_o    <= next_invalid;
      boot_from_strap_o <= done && strap_sel;
      boot_medium_o     <= next_medium;
      boot_code_o       <= done ? code : 4'h0;
      static_width_o    <= next_width;
      pin_fn            <= next_fn;
      fetch_from_rom_o  <= 1'b1;                                            // [RQ13]
    end
  end

  // each medium enable is a decode of the registered medium
  assign serial_port_zero_en_o           = (boot_medium_o == bsel_pkg::BSEL_MED_SER0);
  assign serial_port_three_en_o          = (boot_medium_o == bsel_pkg::BSEL_MED_SER3);
  assign quad_flash_interface_en_o       = (boot_medium_o == bsel_pkg::BSEL_MED_QFLASH);
  assign static_chip_select_zero_en_o    = (boot_medium_o == bsel_pkg::BSEL_MED_SMEM8) ||
                                           (boot_medium_o == bsel_pkg::BSEL_MED_SMEM16) ||
                                           (boot_medium_o == bsel_pkg::BSEL_MED_SMEM32);
  assign external_memory_controller_en_o = static_chip_select_zero_en_o;
  assign usb_port_first_en_o             = (boot_medium_o == bsel_pkg::BSEL_MED_USB1ST);
  assign usb_port_second_en_o            = (boot_medium_o == bsel_pkg::BSEL_MED_USB2ND);
  assign sync_serial_port_zero_en_o      = (boot_medium_o == bsel_pkg::BSEL_MED_SSPI);
  // the four fixed pins share one function code
  assign sync_serial_clock_fn_o          = pin_fn;                          // [RQ7]
  assign sync_serial_slave_select_fn_o   = pin_fn;                          // [RQ7]
  assign sync_serial_master_in_fn_o      = pin_fn;                          // [RQ7]
  assign sync_serial_master_out_fn_o     = pin_fn;                          // [RQ7]
  // cpu always starts at the rom base after any reset
  assign fetch_addr_o                    = bsel_pkg::BOOT_ROM_BASE;         // [RQ13]

  ////////////////////////////////////////////////////////////////////////////
  // assertions

  property p_strap_fallback;
    @(posedge mclk_i) disable iff (sys_rst_i)
    (state == BSEL_ST_CAPTURE) && use_strap |=> strap_sel && (code == $past(strap_code));
  endproperty
  a_strap_fallback: assert property (p_strap_fallback) else $error("strap fallback lost"); // [RQ1]

  property p_field_used;
    @(posedge mclk_i) disable iff (sys_rst_i)
    (state == BSEL_ST_CAPTURE) && !use_strap |=>
      !strap_sel && (code == $past(boot_source_field_i));
  endproperty
  a_field_used: assert property (p_field_used) else $error("fuse field not used"); // [RQ1]

  property p_field_ser0;
    @(posedge mclk_i) disable iff (sys_rst_i)
    done && !strap_sel && (code == bsel_pkg::FLD_SER0) |=> serial_port_zero_en_o;
  endproperty
  a_field_ser0: assert property (p_field_ser0) else $error("field 0001 not serial zero"); // [RQ2]

  property p_field_qflash;
    @(posedge mclk_i) disable iff (sys_rst_i)
    done && !strap_sel && (code == bsel_pkg::FLD_QFLASH) |=> quad_flash_interface_en_o
      && (sync_serial_clock_fn_o == bsel_pkg::PFN_QFLASH);
  endproperty
  a_field_qflash: assert property (p_field_qflash) else $error("field 0010 not qflash"); // [RQ3]

  property p_smem_width;
    @(posedge mclk_i) disable iff (sys_rst_i)
    done && !strap_sel && (code == bsel_pkg::FLD_SMEM32) |=>
      static_chip_select_zero_en_o && (static_width_o == bsel_pkg::SMW_32);
  endproperty
  a_smem_width: assert property (p_smem_width) else $error("field 0101 not 32 bit"); // [RQ4]

  property p_usb;
    @(posedge mclk_i) disable iff (sys_rst_i)
    done && !strap_sel && (code == bsel_pkg::FLD_USB2ND) |=> usb_port_second_en_o;
  endproperty
  a_usb: assert property (p_usb) else $error("field 0111 not usb two"); // [RQ5]

  property p_sspi_pins;
    @(posedge mclk_i) disable iff (sys_rst_i)
    sync_serial_port_zero_en_o |-> (sync_serial_master_out_fn_o == bsel_pkg::PFN_SSP);
  endproperty
  a_sspi_pins: assert property (p_sspi_pins) else $error("sync serial pins wrong"); // [RQ7]

  property p_strap_zero;
    @(posedge mclk_i) disable iff (sys_rst_i)
    done && strap_sel && (code == bsel_pkg::STR_SER0) |=> serial_port_zero_en_o;
  endproperty
  a_strap_zero: assert property (p_strap_zero) else $error("straps low not serial zero"); // [RQ10]

  property p_strap_ser3;
    @(posedge mclk_i) disable iff (sys_rst_i)
    done && strap_sel && (code == bsel_pkg::STR_SER3) |=> serial_port_three_en_o;
  endproperty
  a_strap_ser3: assert property (p_strap_ser3) else $error("strap 1000 not port three"); // [RQ12]

  property p_invalid;
    @(posedge mclk_i) disable iff (sys_rst_i)
    boot_invalid_o |-> (boot_medium_o == bsel_pkg::BSEL_MED_NONE) && !boot_valid_o;
  endproperty
  a_invalid: assert property (p_invalid) else $error("reserved code picked medium"); // [RQ14]

  property p_settle;
    @(posedge mclk_i) disable iff (sys_rst_i)
    $rose(state == BSEL_ST_DONE) |=> (boot_valid_o || boot_invalid_o) [*3];
  endproperty
  a_settle: assert property (p_settle) else $error("boot result not held"); // [RQ13]

  c_strap_boot: cover property (@(posedge mclk_i) disable iff (sys_rst_i)
    boot_valid_o && boot_from_strap_o);
  c_fuse_boot: cover property (@(posedge mclk_i) disable iff (sys_rst_i)
    boot_valid_o && !boot_from_strap_o);
  c_reserved: cover property (@(posedge mclk_i) disable iff (sys_rst_i) boot_invalid_o);
  c_sspi: cover property (@(posedge mclk_i) disable iff (sys_rst_i) sync_serial_port_zero_en_o);

endmodule

// *** tb/bsel_strap_board.sv ***
// bsel_strap_board: board side of the boot selector, fuse bits and strap pins
// assumes: the bench sets fuse state and a strap code, levels held across reset
`timescale 1ns/1ns
module bsel_strap_board (
  input  wire logic       prog_i,
  input  wire logic [3:0] field_i,
  input  wire logic [3:0] code_i,
  output logic            fuse_programmed_o,
  output logic [3:0]      boot_source_field_o,
  output logic            strap_pin_3_o,
  output logic            strap_pin_2_o,
  output logic            strap_pin_1_o,
  output logic            strap_pin_0_o
);
  ////////////////////////////////////////////////////////////////////////////
  // fuse array: a blank array still presents its field, so the selector
  // must ignore the field on its own rather than rely on a zero read
  assign fuse_programmed_o   = prog_i;
  assign boot_source_field_o = field_i;
  ////////////////////////////////////////////////////////////////////////////
  // straps tied by the board, strap 3 carries the code msb
  assign strap_pin_3_o = code_i[3];
  assign strap_pin_2_o = code_i[2];
  assign strap_pin_1_o = code_i[1];
  assign strap_pin_0_o = code_i[0];
endmodule

// *** tb/tb.sv ***
// tb: self-checking bench for the boot source selector
// assumes: one clock at 50 MHz, synchronous active high reset, board model drives pins
`timescale 1ns/1ns
module tb;
  logic                   mclk_i = 1'b0;
  logic                   sys_rst_i = 1'b1;
  logic                   prog = 1'b0;
  logic [3:0]             field = 4'h0;
  logic [3:0]             straps = 4'h0;
  logic                   fp_w;
  logic [3:0]             fld_w;
  logic                   s3_w;
  logic                   s2_w;
  logic                   s1_w;
  logic                   s0_w;
  logic                   vld;
  logic                   inv;
  logic                   frs;
  bsel_pkg::bsel_medium_t med;
  logic [3:0]             code;
  wire logic [7:0]        en;
  logic [1:0]             wid;
  logic [2:0]             fn_ck;
  logic [2:0]             fn_ss;
  logic [2:0]             fn_mi;
  logic [2:0]             fn_mo;
  logic                   rom;
  logic [31:0]            addr;
  int                     bad_count = 0;
  int                     check_count = 0;
  int                     cycles = 0;

  always #10 mclk_i = ~mclk_i;

  bsel_strap_board u_board (.prog_i(prog), .field_i(field), .code_i(straps),
    .fuse_programmed_o(fp_w), .boot_source_field_o(fld_w), .strap_pin_3_o(s3_w),
    .strap_pin_2_o(s2_w), .strap_pin_1_o(s1_w), .strap_pin_0_o(s0_w));

  bsel_boot_source_selector u_dut (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i),
    .fuse_programmed_i(fp_w), .boot_source_field_i(fld_w), .strap_pin_3_i(s3_w),
    .strap_pin_2_i(s2_w), .strap_pin_1_i(s1_w), .strap_pin_0_i(s0_w),
    .boot_valid_o(vld), .boot_invalid_o(inv), .boot_from_strap_o(frs),
    .boot_medium_o(med), .boot_code_o(code), .serial_port_zero_en_o(en[0]),
    .serial_port_three_en_o(en[1]), .quad_flash_interface_en_o(en[2]),
    .external_memory_controller_en_o(en[3]), .static_chip_select_zero_en_o(en[4]),
    .static_width_o(wid), .usb_port_first_en_o(en[5]), .usb_port_second_en_o(en[6]),
    .sync_serial_port_zero_en_o(en[7]), .sync_serial_clock_fn_o(fn_ck),
    .sync_serial_slave_select_fn_o(fn_ss), .sync_serial_master_in_fn_o(fn_mi),
    .sync_serial_master_out_fn_o(fn_mo), .fetch_from_rom_o(rom), .fetch_addr_o(addr));

  ////////////////////////////////////////////////////////////////////////////
  // verdict and compare helpers
  task automatic test_done();
    if (bad_count == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic check_vec(input string name, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", name, exp, got);
    end
  endtask

  // hang guard, a full run needs a few hundred cycles
  always @(posedge mclk_i) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      bad_count++;
      test_done();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // one boot: reset with given inputs, then judge outputs exactly 3 edges later
  task automatic run_boot(input logic p, input logic [3:0] f, input logic [3:0] s,
                          input logic [3:0] em, input logic es, input logic ei);
    logic [2:0] efn;
    logic [1:0] ew;
    efn = (em == 4'h2) ? bsel_pkg::PFN_QFLASH : (em == 4'h8) ? bsel_pkg::PFN_SSP
                                                              : bsel_pkg::PFN_GPIO;
    ew = (em == 4'h4) ? bsel_pkg::SMW_16 : (em == 4'h5) ? bsel_pkg::SMW_32 : bsel_pkg::SMW_8;
    // let the previous result stand long enough for the settle and medium checks
    repeat (4) @(posedge mclk_i);
    sys_rst_i <= 1'b1;
    prog <= p;
    field <= f;
    straps <= s;
    repeat (2) @(posedge mclk_i);
    #1 check_vec("valid_in_reset", 32'h0, vld);
    check_vec("rom_in_reset", 32'h1, rom);
    @(posedge mclk_i);
    sys_rst_i <= 1'b0;
    repeat (2) @(posedge mclk_i);
    #1 check_vec("valid_early", 32'h0, {inv, vld});
    @(posedge mclk_i);
    #1 check_vec("valid", {31'h0, ~ei}, vld);
    check_vec("invalid", {31'h0, ei}, inv);
    check_vec("from_strap", {31'h0, es}, frs);
    check_vec("medium", {28'h0, em}, med);
    check_vec("code", {28'h0, es ? s : f}, code);
    check_vec("enables", {24'h0, em == 4'h8, em == 4'h7, em == 4'h6,
      em inside {[4'h3:4'h5]}, em inside {[4'h3:4'h5]}, em == 4'h2, em == 4'h9,
      em == 4'h1}, en);
    check_vec("width", {30'h0, ew}, wid);
    check_vec("pin_fn", {20'h0, efn, efn, efn, efn}, {fn_ck, fn_ss, fn_mi, fn_mo});
    check_vec("fetch", 32'h1, {31'h0, rom});
    check_vec("fetch_addr", bsel_pkg::BOOT_ROM_BASE, addr);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_fuse_modes();
    // listed field codes 1..9 map to media 1..9 in listed order; straps set to
    // something else so a strap fallback would show
    for (int i = 1; i <= 9; i++) begin
      run_boot(1'b1, 4'(i), 4'h6, 4'(i), 1'b0, 1'b0);
    end
  endtask

  task automatic t_strap_modes();
    // strap codes 0..8 map to media 1..9; fuse blank with a live field
    for (int i = 0; i <= 8; i++) begin
      run_boot(1'b0, 4'h9, 4'(i), 4'(i + 1), 1'b1, 1'b0);
    end
  endtask

  task automatic t_zero_field();
    // programmed but zero field falls back to straps
    run_boot(1'b1, 4'h0, 4'h1, 4'h2, 1'b1, 1'b0);
    run_boot(1'b1, 4'h0, 4'h7, 4'h8, 1'b1, 1'b0);
  endtask

  task automatic t_reserved();
    for (int i = 10; i <= 15; i++) begin
      run_boot(1'b1, 4'(i), 4'h1, 4'h0, 1'b0, 1'b1);
    end
    for (int i = 9; i <= 15; i++) begin
      run_boot(1'b0, 4'h2, 4'(i), 4'h0, 1'b1, 1'b1);
    end
  endtask

  task automatic t_stand();
    // inputs moving after capture must not disturb the result
    run_boot(1'b1, 4'h8, 4'h0, 4'h8, 1'b0, 1'b0);
    @(posedge mclk_i);
    field <= 4'h2;
    prog <= 1'b0;
    straps <= 4'h3;
    repeat (4) @(posedge mclk_i);
    #1 check_vec("medium_held", {28'h0, bsel_pkg::BSEL_MED_SSPI}, med);
    check_vec("pin_fn_held", {29'h0, bsel_pkg::PFN_SSP}, fn_ck);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    repeat (12) @(posedge mclk_i);
    t_fuse_modes();
    t_strap_modes();
    t_zero_field();
    t_reserved();
    t_stand();
    test_done();
  end
endmodule
